// File: core/tpc_pkg.sv
// Constants, register map and types for the timing processor host control
package tpc_pkg;
	// Clock and time base
	localparam int          CLK_NS     = 100;
	localparam int          TICK_NS    = 10000;
	localparam int          TICK_CYC   = TICK_NS / CLK_NS;
	localparam logic [6:0]  PRE_LAST   = 7'(TICK_CYC - 1);
	localparam logic [17:0] TPS        = 18'(1000000000 / TICK_NS);
	localparam int          ADJ_MS     = 100;
	localparam logic [13:0] ADJ_MAX    = 14'(ADJ_MS * 1000000 / TICK_NS);
	localparam int          DAY_S      = 86400;
	localparam logic [31:0] YEAR_SHORT = 32'(365 * DAY_S);
	localparam logic [31:0] YEAR_LONG  = 32'(366 * DAY_S);

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_TREQ    = 8'h04;
	localparam logic [7:0] OFS_EREQ    = 8'h08;
	localparam logic [7:0] OFS_UNLOCK  = 8'h0C;
	localparam logic [7:0] OFS_TMAJ    = 8'h10;
	localparam logic [7:0] OFS_TMIN    = 8'h14;
	localparam logic [7:0] OFS_EMAJ    = 8'h18;
	localparam logic [7:0] OFS_EMIN    = 8'h1C;
	localparam logic [7:0] OFS_SMAJ    = 8'h20;
	localparam logic [7:0] OFS_SMIN    = 8'h24;
	localparam logic [7:0] OFS_ISTAT   = 8'h28;
	localparam logic [7:0] OFS_DAC     = 8'h2C;
	localparam logic [7:0] OFS_SETMAJ  = 8'h30;
	localparam logic [7:0] OFS_ADJ     = 8'h34;
	localparam logic [7:0] OFS_YEAR    = 8'h38;
	localparam logic [7:0] OFS_CMD     = 8'h3C;
	localparam logic [7:0] OFS_E2MAJ   = 8'h40;
	localparam logic [7:0] OFS_E2MIN   = 8'h44;
	localparam logic [7:0] OFS_E3MAJ   = 8'h48;
	localparam logic [7:0] OFS_E3MIN   = 8'h4C;
	localparam logic [7:0] OFS_LOCOFF  = 8'h50;
	localparam logic [7:0] OFS_LEAP    = 8'h54;
	localparam logic [7:0] OFS_LEAPAT  = 8'h58;
	localparam logic [7:0] OFS_PERIOD  = 8'h5C;
	localparam logic [2:0] DP_BASE     = 3'h4;

	// Control register fields
	localparam int C_MODE = 0;
	localparam int C_BIN  = 2;
	localparam int C_LOCK = 3;
	localparam int C_STB  = 4;
	localparam int C_USON = 5;
	localparam int C_LOC  = 6;
	localparam int C_YINC = 7;
	localparam int C_GFMT = 8;
	localparam int C_SDIS = 9;
	localparam int C_PSYN = 10;
	localparam int C_FREQ = 11;
	localparam logic [1:0] MODE_GPS = 2'h2;

	// Command register bits, leap register fields
	localparam int K_SEND = 0;
	localparam int K_SRST = 1;
	localparam int K_SYNC = 2;
	localparam int K_DISC = 3;
	localparam int L_ARM  = 8;
	localparam int L_DEL  = 9;

	// Interrupt flag bits
	localparam int I_EVT  = 0;
	localparam int I_STB  = 1;
	localparam int I_PPS  = 2;
	localparam int I_EV2  = 3;
	localparam int I_EV3  = 4;
	localparam int I_DONE = 5;
	localparam int I_PKT  = 6;

	// Command codes and locally kept packet ids (ids arbitrary)
	localparam logic [7:0] CMD_PKT = 8'h31;
	localparam logic [7:0] MON_A   = 8'h01;
	localparam logic [7:0] MON_B   = 8'h02;
	localparam logic [7:0] MON_C   = 8'h03;
	localparam logic [15:0] DAC_RST = 16'h8000;

	typedef enum logic [1:0] {
		CS_IDLE = 2'b00,
		CS_EXEC = 2'b01,
		CS_WAIT = 2'b10
	} tpc_cmd_type;

	typedef struct packed {
		logic              ack;
		logic [31:0]       rdat;
		logic [15:0]       ctrl;
		logic [31:0]       major;
		logic [16:0]       minor;
		logic [6:0]        pre;
		logic [15:0]       adj;
		logic [13:0]       budget;
		logic [31:0]       tmaj;
		logic [16:0]       tmin;
		logic [31:0]       emaj;
		logic [16:0]       emin;
		logic [31:0]       e2maj;
		logic [16:0]       e2min;
		logic [31:0]       e3maj;
		logic [16:0]       e3min;
		logic [31:0]       smaj;
		logic [16:0]       smin;
		logic              shold;
		logic              locked;
		logic [7:0]        istat;
		logic [15:0]       dac;
		logic [15:0]       year;
		logic [31:0]       locoff;
		logic [9:0]        leap;
		logic [31:0]       leapat;
		logic [23:0]       period;
		logic [23:0]       pcnt;
		logic              pout;
		logic              strobe;
		logic              pps;
		logic [2:0]        evp;
		logic              trk;
		logic              gstatic;
		logic [7:0][7:0]   dp;
		tpc_cmd_type       cst;
		logic              greq;
		logic [7:0]        gid;
		logic              rtcwr;
		logic [31:0]       rtcsec;
		logic              bdisc;
		logic              nvwr;
	} tpc_state_type;
endpackage

// File: core/tpc_host_ctrl.sv
// Host control of the timing processor: captures, strobe, flags, commands
// How it works
// - Writing a capture request latches running time or event time.
// - Reading capture registers returns held values, never captures anew.
// - Strobe output stays off while compare registers are being loaded.
// - Setting major time leaves the sub-second counter untouched.
// - With lockout on, first event input captures wait until the release write.
// - Flag register fully readable, each bit clearable by the host.
// - Advance or retard by count times 10 us, max 100 ms per second.
// - Year auto-increment bumps the year and stores it to nonvolatile.
// - Synchronise command copies current time into the battery clock.
// - Battery disconnect holds until power-on reset reconnects it.
// - Send command forwards the staged command for execution.
// - Kept packets answer at once, others are fetched from receiver.
// - Outside satellite mode one leap second can be inserted or deleted.
// - Fixed clock output selectable among 1, 5 and 10 MHz.
// - Programming the periodic rate also turns on pps-synchronous mode.
// - In satellite mode the receiver is put in static mode once tracking, unless disabled.
// - Satellite format setting decides leap offset correction.
// - Oscillator DAC value is written and read back by the host.
// - Second and third event inputs have capture registers of their own.
// - Software reset command resets the timing logic.
// - Local offset applies to reported time only while enabled.
`timescale 1ns/10ps
module tpc_host_ctrl
	import tpc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        ext_evt,
	input  wire logic        ext_evt2,
	input  wire logic        ext_evt3,
	input  wire logic [31:0] gps_sec,
	input  wire logic        gps_sec_vld,
	input  wire logic        gps_trk,
	input  wire logic        gps_pkt_rdy,
	output logic             strobe_out,
	output logic             pps_out,
	output logic             periodic_out,
	output logic [1:0]       freq_sel,
	output logic [15:0]      dac_out,
	output logic             gps_req,
	output logic [7:0]       gps_req_id,
	output logic             gps_static,
	output logic             rtc_wr,
	output logic [31:0]      rtc_sec,
	output logic             batt_disc,
	output logic             year_nv_wr,
	output logic [15:0]      year_nv
);

	tpc_state_type q;
	tpc_state_type n;

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] wb_merge(
		input logic [31:0] o,
		input logic [31:0] d,
		input logic [3:0]  s
	);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Reported major time, local offset only when enabled
	function automatic logic [31:0] rep_major(input tpc_state_type s);
		rep_major = s.ctrl[C_LOC] ? s.major + s.locoff : s.major;
	endfunction

	function automatic logic [31:0] year_len(input logic [15:0] y);
		year_len = (y[1:0] == 2'h0) ? YEAR_LONG : YEAR_SHORT;
	endfunction

	function automatic logic kept_pkt(input logic [7:0] id);
		kept_pkt = (id == MON_A) || (id == MON_B) || (id == MON_C);
	endfunction

	logic        tick;
	logic        sec;
	logic        acc;
	logic        idle;
	logic        srst;
	logic [1:0]  step;
	logic [1:0]  inc;
	logic [17:0] mn;
	logic [31:0] ns;
	logic [31:0] wd;
	logic [31:0] rd;
	logic [7:0]  setm;
	logic [2:0]  evr;
	logic [7:0]  adr;

	// Whole next-state computation
	always_comb begin
		n = q;
		n.ack = 1'b0;
		n.strobe = 1'b0;
		n.pps = 1'b0;
		n.greq = 1'b0;
		n.gstatic = 1'b0;
		n.rtcwr = 1'b0;
		n.nvwr = 1'b0;
		tick = 1'b0;
		sec = 1'b0;
		srst = 1'b0;
		step = 2'h1;
		inc = 2'h1;
		mn = 18'h00000;
		ns = 32'h00000000;
		setm = 8'h00;
		rd = 32'h00000000;
		adr = {wb_adr_i[7:2], 2'b00};
		acc = wb_cyc_i && wb_stb_i && !q.ack;
		idle = (q.cst == CS_IDLE);
		evr = {ext_evt3, ext_evt2, ext_evt} & ~q.evp;
		n.evp = {ext_evt3, ext_evt2, ext_evt};
		wd = wb_merge(32'h00000000, wb_dat_i, wb_sel_i);

		// 10 us prescaler
		if (q.pre == PRE_LAST) begin
			n.pre = 7'h00;
			tick = 1'b1;
		end else begin
			n.pre = q.pre + 7'h01;
		end

		// Slew: one extra or one skipped tick, budget per second
		if (tick) begin
			if (q.adj != 16'h0000 && q.budget != 14'h0000) begin
				step = q.adj[15] ? 2'h0 : 2'h2;
				n.adj = q.adj[15] ? q.adj + 16'h0001
					: q.adj - 16'h0001;
				n.budget = q.budget - 14'h0001;
			end
			mn = {1'b0, q.minor} + {16'h0000, step};
			if (mn >= TPS) begin
				n.minor = 17'(mn - TPS);
				sec = 1'b1;
			end else begin
				n.minor = mn[16:0];
			end
			// Periodic divider in ticks
			if (q.period != 24'h000000) begin
				if (q.pcnt >= q.period - 24'h000001) begin
					n.pcnt = 24'h000000;
					n.pout = !q.pout;
				end else begin
					n.pcnt = q.pcnt + 24'h000001;
				end
			end
		end

		// Second boundary: leap handling, year roll
		if (sec) begin
			n.pps = 1'b1;
			setm[I_PPS] = 1'b1;
			n.budget = ADJ_MAX;
			if (q.leap[L_ARM] && q.ctrl[C_MODE +: 2] != MODE_GPS
				&& q.major == q.leapat) begin
				inc = q.leap[L_DEL] ? 2'h2 : 2'h0;
				n.leap[L_ARM] = 1'b0;
			end
			ns = q.major + {30'h00000000, inc};
			if (ns >= year_len(q.year)) begin
				ns = ns - year_len(q.year);
				if (q.ctrl[C_YINC]) begin
					n.year = q.year + 16'h0001;
					n.nvwr = 1'b1;
				end
			end
			n.major = ns;
			if (q.ctrl[C_PSYN]) begin
				n.pcnt = 24'h000000;
				n.pout = 1'b1;
			end
		end

		// Satellite time load and static-mode request
		if (q.ctrl[C_MODE +: 2] == MODE_GPS) begin
			if (gps_sec_vld) begin
				n.major = q.ctrl[C_GFMT]
					? gps_sec - {24'h000000, q.leap[7:0]}
					: gps_sec;
			end
			if (gps_trk && !q.trk && !q.ctrl[C_SDIS]) begin
				n.gstatic = 1'b1;
			end
		end
		n.trk = gps_trk;

		// Coincidence strobe, held off while compare is reloaded
		if (tick && q.ctrl[C_STB] && !q.shold
			&& !(acc && wb_we_i && (adr == OFS_SMAJ || adr == OFS_SMIN))
			&& q.minor == q.smin
			&& (q.ctrl[C_USON] || q.major == q.smaj)) begin
			n.strobe = 1'b1;
			setm[I_STB] = 1'b1;
		end

		// Read mux: plain copies of held values, no side effects
		unique case (adr)
			OFS_CTRL:   rd = {16'h0000, q.ctrl};
			OFS_TMAJ:   rd = q.tmaj;
			OFS_TMIN:   rd = {15'h0000, q.tmin};
			OFS_EMAJ:   rd = q.emaj;
			OFS_EMIN:   rd = {15'h0000, q.emin};
			OFS_SMAJ:   rd = q.smaj;
			OFS_SMIN:   rd = {15'h0000, q.smin};
			OFS_ISTAT:  rd = {24'h000000, q.istat};
			OFS_DAC:    rd = {16'h0000, q.dac};
			OFS_ADJ:    rd = {16'h0000, q.adj};
			OFS_YEAR:   rd = {16'h0000, q.year};
			OFS_CMD:    rd = {31'h00000000, !idle};
			OFS_E2MAJ:  rd = q.e2maj;
			OFS_E2MIN:  rd = {15'h0000, q.e2min};
			OFS_E3MAJ:  rd = q.e3maj;
			OFS_E3MIN:  rd = {15'h0000, q.e3min};
			OFS_LOCOFF: rd = q.locoff;
			OFS_LEAP:   rd = {22'h000000, q.leap};
			OFS_LEAPAT: rd = q.leapat;
			OFS_PERIOD: rd = {8'h00, q.period};
			default: begin
				if (adr[7:5] == DP_BASE) begin
					rd = {24'h000000, q.dp[adr[4:2]]};
				end
			end
		endcase

		// Bus access: one-cycle answer, unmapped writes ignored
		if (acc) begin
			n.ack = 1'b1;
			n.rdat = wb_we_i ? 32'h00000000 : rd;
			if (wb_we_i) begin
				unique case (adr)
					OFS_CTRL: n.ctrl = 16'(wb_merge({16'h0000, q.ctrl},
						wb_dat_i, wb_sel_i));
					OFS_TREQ: begin
						n.tmaj = rep_major(q);
						n.tmin = q.minor;
					end
					OFS_EREQ: begin
						if (!q.locked) begin
							n.emaj = rep_major(q);
							n.emin = q.minor;
							n.locked = q.ctrl[C_LOCK];
						end
					end
					OFS_UNLOCK: n.locked = 1'b0;
					OFS_SMAJ: begin
						n.smaj = wb_merge(q.smaj, wb_dat_i, wb_sel_i);
						n.shold = 1'b1;
					end
					OFS_SMIN: begin
						n.smin = 17'(wb_merge({15'h0000, q.smin}, wb_dat_i,
							wb_sel_i));
						n.shold = 1'b0;
					end
					OFS_ISTAT: n.istat = q.istat & ~wd[7:0];
					OFS_DAC: n.dac = 16'(wb_merge({16'h0000, q.dac},
						wb_dat_i, wb_sel_i));
					OFS_SETMAJ: n.major = wb_merge(q.major, wb_dat_i,
						wb_sel_i);
					OFS_ADJ: begin
						n.adj = wd[15:0];
					end
					OFS_YEAR: n.year = 16'(wb_merge({16'h0000, q.year},
						wb_dat_i, wb_sel_i));
					OFS_CMD: begin
						if (idle && wd[K_SEND]) begin
							n.cst = CS_EXEC;
						end
						srst = wd[K_SRST];
						if (wd[K_SYNC]) begin
							n.rtcwr = 1'b1;
							n.rtcsec = q.major;
						end
						if (wd[K_DISC]) begin
							n.bdisc = 1'b1;
						end
					end
					OFS_LOCOFF: n.locoff = wb_merge(q.locoff, wb_dat_i,
						wb_sel_i);
					OFS_LEAP: n.leap = wd[9:0];
					OFS_LEAPAT: n.leapat = wb_merge(q.leapat, wb_dat_i,
						wb_sel_i);
					OFS_PERIOD: begin
						n.period = 24'(wb_merge({8'h00, q.period}, wb_dat_i,
							wb_sel_i));
						n.ctrl[C_PSYN] = 1'b1;
					end
					default: begin
						// Staging area is frozen while a command runs
						if (adr[7:5] == DP_BASE && idle && wb_sel_i[0]) begin
							n.dp[adr[4:2]] = wb_dat_i[7:0];
						end
					end
				endcase
			end
		end

		// External events, seen after any release in this cycle
		if (evr[0] && !n.locked) begin
			n.emaj = rep_major(q);
			n.emin = q.minor;
			n.locked = q.ctrl[C_LOCK];
			setm[I_EVT] = 1'b1;
		end
		if (evr[1]) begin
			n.e2maj = rep_major(q);
			n.e2min = q.minor;
			setm[I_EV2] = 1'b1;
		end
		if (evr[2]) begin
			n.e3maj = rep_major(q);
			n.e3min = q.minor;
			setm[I_EV3] = 1'b1;
		end

		// Command engine
		unique case (q.cst)
			CS_IDLE: begin
			end
			CS_EXEC: begin
				if (q.dp[0] == CMD_PKT && !kept_pkt(q.dp[1])) begin
					n.greq = 1'b1;
					n.gid = q.dp[1];
					n.cst = CS_WAIT;
				end else begin
					if (q.dp[0] == CMD_PKT) begin
						setm[I_PKT] = 1'b1;
					end
					setm[I_DONE] = 1'b1;
					n.cst = CS_IDLE;
				end
			end
			CS_WAIT: begin
				if (gps_pkt_rdy) begin
					setm[I_PKT] = 1'b1;
					setm[I_DONE] = 1'b1;
					n.cst = CS_IDLE;
				end
			end
			default: n.cst = CS_IDLE;
		endcase

		// Hardware sets win over a clear in the same cycle
		n.istat = n.istat | setm;

		// Software reset of timing logic and leap setting; bus, other settings, battery kept
		if (srst) begin
			n.major = 32'h00000000;
			n.minor = 17'h00000;
			n.pre = 7'h00;
			n.adj = 16'h0000;
			n.budget = ADJ_MAX;
			n.locked = 1'b0;
			n.shold = 1'b0;
			n.istat = 8'h00;
			n.pcnt = 24'h000000;
			n.pout = 1'b0;
			n.leap = 10'h000;
			n.cst = CS_IDLE;
		end
	end

	// State register; clock enable freezes everything
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
			q.budget <= ADJ_MAX;
			q.dac <= DAC_RST;
			q.cst <= CS_IDLE;
		end else if (ce) begin
			q <= n;
		end
	end

	// Outputs straight from state flops
	assign wb_dat_o = q.rdat;
	assign wb_ack_o = q.ack;
	assign strobe_out = q.strobe;
	assign pps_out = q.pps;
	assign periodic_out = q.pout;
	assign freq_sel = q.ctrl[C_FREQ +: 2];
	assign dac_out = q.dac;
	assign gps_req = q.greq;
	assign gps_req_id = q.gid;
	assign gps_static = q.gstatic;
	assign rtc_wr = q.rtcwr;
	assign rtc_sec = q.rtcsec;
	assign batt_disc = q.bdisc;
	assign year_nv_wr = q.nvwr;
	assign year_nv = q.year;

endmodule

// File: bench/tpc_host_ctrl_properties.sv
// Concurrent checks on the host control ports, bound to the block
`timescale 1ns/10ps
module tpc_host_ctrl_props
	import tpc_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic        strobe_out,
	input wire logic [1:0]  freq_sel,
	input wire logic [15:0] dac_out,
	input wire logic        gps_req,
	input wire logic [7:0]  gps_req_id,
	input wire logic        rtc_wr,
	input wire logic        batt_disc
);
	logic take;
	logic wfull;
	logic hold_r;
	logic hold_nxt;

	// A request is taken only while no answer is standing
	assign take  = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
	assign wfull = take && wb_we_i && wb_sel_i == 4'hF;

	// Window from compare major load until compare minor load
	always_comb begin
		hold_nxt = hold_r;
		if (wfull && wb_adr_i == OFS_SMAJ)
			hold_nxt = 1'b1;
		if (wfull && wb_adr_i == OFS_SMIN)
			hold_nxt = 1'b0;
	end

	// Cleared by reset so no stale window survives it
	always_ff @(posedge sys_clk) begin
		if (rst)
			hold_r <= 1'b0;
		else
			hold_r <= hold_nxt;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	AST_ACK_ANSWER: assert property (take |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stood longer than one cycle");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(take))
		else $error("ack without a taken request");
	AST_STROBE_HELD: assert property (hold_r && $past(hold_r) |-> !strobe_out)
		else $error("strobe fired while compare was being loaded");
	AST_DAC_LOAD: assert property (wfull && wb_adr_i == OFS_DAC
		|=> dac_out == $past(wb_dat_i[15:0]))
		else $error("dac output does not follow write");
	AST_FREQ_SEL: assert property (wfull && wb_adr_i == OFS_CTRL
		|=> freq_sel == $past(wb_dat_i[12:11]))
		else $error("frequency select does not follow control");
	AST_RTC_COPY: assert property (wfull && wb_adr_i == OFS_CMD
		&& wb_dat_i[K_SYNC] |-> ##[1:2] rtc_wr)
		else $error("sync command gave no battery clock write");
	AST_BATT_KEEP: assert property (batt_disc |=> batt_disc)
		else $error("battery disconnect dropped without reset");
	AST_BATT_CAUSE: assert property ($rose(batt_disc) |->
		$past(wfull && wb_adr_i == OFS_CMD && wb_dat_i[K_DISC]))
		else $error("battery disconnect without command");
	AST_KEPT_LOCAL: assert property (gps_req |-> gps_req_id != MON_A
		&& gps_req_id != MON_B && gps_req_id != MON_C)
		else $error("kept packet fetched from receiver");
	AST_REQ_PULSE: assert property (gps_req |=> !gps_req)
		else $error("fetch request longer than one cycle");

	COV_STROBE_LOAD: cover property (wfull && wb_adr_i == OFS_SMIN);
	COV_FETCH: cover property (gps_req);
	COV_RTC: cover property (rtc_wr);
	COV_BATT: cover property ($rose(batt_disc));
endmodule

bind tpc_host_ctrl tpc_host_ctrl_props u_props (.sys_clk, .rst, .ce,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_ack_o, .strobe_out, .freq_sel, .dac_out, .gps_req, .gps_req_id,
	.rtc_wr, .batt_disc);

// File: bench/tpc_gps_model.sv
// Receiver model: answers a packet fetch after a chosen delay
`timescale 1ns/10ps
module tpc_gps_model (
	input  wire logic        sys_clk,
	input  wire logic        gps_req,
	input  wire logic [31:0] delay,
	output logic             gps_pkt_rdy
);
	int cnt = 0;

	// Slow answers stand in for the real receiver's long turnaround
	always @(posedge sys_clk) begin
		gps_pkt_rdy <= 1'b0;
		if (gps_req)
			cnt <= int'(delay) + 1;
		else if (cnt > 0)
			cnt <= cnt - 1;
		if (!gps_req && cnt == 1)
			gps_pkt_rdy <= 1'b1;
	end
endmodule

// File: bench/tpc_host_ctrl_tb.sv
// Self-checking bench for the timing processor host control block
`timescale 1ns/10ps
module tpc_host_ctrl_tb
	import tpc_pkg::*;
;
	logic        sys_clk, rst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i, gps_req_id;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, gps_sec, rtc_sec, dly, q, s, m1, v;
	logic [2:0]  evs;
	logic        gps_sec_vld, gps_trk, gps_pkt_rdy, strobe_out, pps_out;
	logic        periodic_out, gps_req, gps_static, rtc_wr, batt_disc;
	logic        year_nv_wr;
	logic [1:0]  freq_sel;
	logic [15:0] dac_out, year_nv;
	logic [7:0]  ids [$];
	int          errors = 0, num_checks = 0, nreq = 0, nstat = 0, n0, k;
	int          nstb = 0;

	tpc_host_ctrl dut (.sys_clk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.ext_evt(evs[0]), .ext_evt2(evs[1]), .ext_evt3(evs[2]), .gps_sec,
		.gps_sec_vld, .gps_trk, .gps_pkt_rdy, .strobe_out, .pps_out,
		.periodic_out, .freq_sel, .dac_out, .gps_req, .gps_req_id,
		.gps_static, .rtc_wr, .rtc_sec, .batt_disc, .year_nv_wr, .year_nv);
	tpc_gps_model gps (.sys_clk, .gps_req, .delay(dly), .gps_pkt_rdy);

	// 10 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// Count receiver fetches and static-mode orders
	always @(posedge sys_clk) begin
		if (gps_req === 1'b1)
			nreq++;
		if (gps_static === 1'b1)
			nstat++;
		if (strobe_out === 1'b1)
			nstb++;
	end

	task automatic chk(input logic [31:0] seen, exp, input string nm);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One classic cycle; request held until ack is sampled high
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20)
			errors++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(q, e, $sformatf("reg %h", a));
	endtask

	// Event lines are sampled, so pulses span two cycles plus settle
	task automatic fire(input logic [2:0] p);
		evs <= p;
		repeat (2) @(posedge sys_clk);
		evs <= 3'h0;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic cap_min();
		bus(OFS_TREQ, 1'b1, 32'h0);
		bus(OFS_TMIN, 1'b0, 32'h0);
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Hang guard well beyond the expected run length
	initial begin
		repeat (80000) @(posedge sys_clk);
		errors++;
		final_report();
	end

	initial begin
		q = $urandom(32'h0D784C25);
		{rst, ce, wb_cyc_i, wb_stb_i, wb_we_i} = 5'b11000;
		{wb_adr_i, wb_sel_i, wb_dat_i, evs} = {8'h00, 4'hF, 32'h0, 3'h0};
		{gps_sec, gps_sec_vld, gps_trk, dly} = {32'h0, 2'b00, 32'h1};
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk({16'h0, dac_out}, 32'h8000, "dac reset");
		rdc(OFS_CTRL, 32'h0);
		rdc(8'hF0, 32'h0);
		v = $urandom;
		bus(OFS_DAC, 1'b1, v);
		rdc(OFS_DAC, {16'h0, v[15:0]});
		// Capture, hold, and major load beside a running minor count
		s = $urandom_range(1000, 31000000);
		repeat (3000) @(posedge sys_clk);
		bus(OFS_SETMAJ, 1'b1, s);
		cap_min();
		m1 = q;
		rdc(OFS_TMAJ, s);
		repeat (500) @(posedge sys_clk);
		rdc(OFS_TMIN, m1);
		s = s + 32'h5;
		bus(OFS_SETMAJ, 1'b1, s);
		cap_min();
		chk(32'(q - m1 >= 5 && q - m1 <= 6 && m1 > 20), 32'h1, "minor");
		rdc(OFS_TMAJ, s);
		// Clock enable low must stop the minor count
		cap_min();
		m1 = q;
		ce <= 1'b0;
		repeat (1000) @(posedge sys_clk);
		ce <= 1'b1;
		cap_min();
		chk(32'(q - m1 <= 32'h1), 32'h1, "freeze");
		// Advance then retard by twenty ticks over thirty ticks
		for (int i = 0; i < 2; i++) begin
			cap_min();
			m1 = q;
			bus(OFS_ADJ, 1'b1, i == 0 ? 32'd20 : 32'hFFFFFFEC);
			repeat (2988) @(posedge sys_clk);
			cap_min();
			k = int'(q - m1) - 30 - (i == 0 ? 20 : -20);
			chk(32'(k >= -1 && k <= 1), 32'h1, "adjust");
		end
		// Event captures, lockout and flag clearing
		bus(OFS_EREQ, 1'b1, 32'h0);
		rdc(OFS_EMAJ, s);
		bus(OFS_ISTAT, 1'b1, 32'hFF);
		bus(OFS_CTRL, 1'b1, 32'h8);
		fire(3'h7);
		rdc(OFS_E2MAJ, s);
		rdc(OFS_E3MAJ, s);
		bus(OFS_EMIN, 1'b0, 32'h0);
		m1 = q;
		repeat (300) @(posedge sys_clk);
		fire(3'h1);
		rdc(OFS_EMIN, m1);
		bus(OFS_UNLOCK, 1'b1, 32'h0);
		fire(3'h1);
		bus(OFS_EMIN, 1'b0, 32'h0);
		chk(32'(q > m1), 32'h1, "event rearm");
		rdc(OFS_ISTAT, 32'h19);
		bus(OFS_ISTAT, 1'b1, 32'h1);
		rdc(OFS_ISTAT, 32'h18);
		bus(OFS_ISTAT, 1'b1, 32'hFF);
		// Local offset only while enabled
		bus(OFS_LOCOFF, 1'b1, 32'd100);
		for (int e = 1; e >= 0; e--) begin
			bus(OFS_CTRL, 1'b1, e == 1 ? 32'h40 : 32'h0);
			bus(OFS_TREQ, 1'b1, 32'h0);
			rdc(OFS_TMAJ, s + (e == 1 ? 32'd100 : 32'h0));
		end
		for (int f = 0; f < 3; f++) begin
			bus(OFS_CTRL, 1'b1, 32'(f) << 11);
			chk({30'h0, freq_sel}, 32'(f), "freq");
		end
		bus(OFS_PERIOD, 1'b1, 32'd50);
		rdc(OFS_CTRL, 32'h1400);
		m1 = {31'h0, periodic_out};
		repeat (50 * TICK_CYC) @(posedge sys_clk);
		chk({31'h0, periodic_out}, m1 ^ 32'h1, "periodic");
		// Strobe held off while major compare loads, minor load re-arms
		bus(OFS_CTRL, 1'b1, 32'h30);
		cap_min();
		m1 = q + 32'd10;
		bus(OFS_SMIN, 1'b1, m1);
		bus(OFS_SMAJ, 1'b1, 32'h0);
		n0 = nstb;
		repeat (1500) @(posedge sys_clk);
		chk(32'(nstb - n0), 32'h0, "strobe held");
		bus(OFS_SMIN, 1'b1, m1 + 32'd20);
		repeat (2500) @(posedge sys_clk);
		chk(32'(nstb - n0), 32'h1, "strobe");
		rdc(OFS_ISTAT, 32'h2);
		bus(OFS_ISTAT, 1'b1, 32'hFF);
		// Staged commands: kept packets at once, others fetched
		ids = {MON_A, MON_B, MON_C, 8'($urandom_range(4, 255)), 8'h04};
		foreach (ids[i]) begin
			dly = i == 3 ? 32'h1 : $urandom_range(20, 300);
			bus(8'h80, 1'b1, {24'h0, CMD_PKT});
			bus(8'h84, 1'b1, {24'h0, ids[i]});
			n0 = nreq;
			bus(OFS_CMD, 1'b1, 32'h1);
			bus(OFS_CMD, 1'b1, 32'h1);
			k = 0;
			do begin
				bus(OFS_CMD, 1'b0, 32'h0);
				k++;
			end while (q[0] === 1'b1 && k < 200);
			chk(32'(k < 200), 32'h1, "cmd done");
			chk(32'(nreq - n0), 32'(ids[i] > 3), "fetches");
			if (ids[i] > 3)
				chk({24'h0, gps_req_id}, {24'h0, ids[i]}, "fetch id");
			rdc(OFS_ISTAT, 32'h60);
			bus(OFS_ISTAT, 1'b1, 32'hFF);
		end
		bus(OFS_CMD, 1'b1, 32'h4);
		repeat (3) @(posedge sys_clk);
		chk(rtc_sec, s, "rtc copy");
		bus(OFS_CMD, 1'b1, 32'h8);
		bus(OFS_CMD, 1'b1, 32'h2);
		chk({31'h0, batt_disc}, 32'h1, "battery");
		bus(OFS_TREQ, 1'b1, 32'h0);
		rdc(OFS_TMAJ, 32'h0);
		rdc(OFS_DAC, {16'h0, v[15:0]});
		// Static order on tracking, unless disabled
		for (int g = 0; g < 2; g++) begin
			bus(OFS_CTRL, 1'b1, g == 0 ? 32'h2 : 32'h202);
			n0 = nstat;
			gps_trk <= 1'b1;
			repeat (5) @(posedge sys_clk);
			chk(32'(nstat - n0), 32'(g == 0), "static");
			gps_trk <= 1'b0;
			repeat (2) @(posedge sys_clk);
		end
		// Satellite time load with leap offset correction
		bus(OFS_LEAP, 1'b1, 32'h12);
		bus(OFS_CTRL, 1'b1, 32'h102);
		gps_sec <= 32'h1000;
		gps_sec_vld <= 1'b1;
		@(posedge sys_clk);
		gps_sec_vld <= 1'b0;
		bus(OFS_TREQ, 1'b1, 32'h0);
		rdc(OFS_TMAJ, 32'h1000 - 32'h12);
		final_report();
	end
endmodule
